// ### logic/ost_clock_ctrl.sv
// Clock source selection, start-up delay sequencing and RC trim register.
// Assumes fuse inputs are steady, and that tick inputs are one-cycle enables.
//
// Our own choices: the placing of the registers and strobed register access.
module ost_clock_ctrl (
    input  wire logic       clk,             // System clock, 50 MHz.
    input  wire logic       rst,             // Asynchronous reset, active high.
    input  wire logic [3:0] clockSourceFuses,// Source select fuse levels.
    input  wire logic [1:0] startupTimeFuses,// Start-up time fuse levels.
    input  wire logic       resetPinDisableFuse, // Low when programmed.
    input  wire logic       divideByEightFuse,   // Low when programmed.
    input  wire logic [7:0] factoryTrim,     // Stored calibration byte.
    input  wire logic       wakeReq,         // Pulse: wake from power-down.
    input  wire logic       srcTick,         // Selected source cycle enable.
    input  wire logic       wdtTick,         // Watchdog oscillator cycle enable.
    input  wire logic [3:0] addr,            // Register address.
    input  wire logic [7:0] wrData,          // Register write data.
    input  wire logic       wrEn,            // Write strobe.
    input  wire logic       rdEn,            // Read strobe.
    output logic      [7:0] rdData,          // Read data, cycle after strobe.
    output logic      [7:0] rcTrimValue,     // Trim word to the RC oscillator.
    output logic            rcSelect,        // RC oscillator is the source.
    output logic            xtalSelect,      // Crystal oscillator is the source.
    output logic      [2:0] oscRangeFuses,   // Crystal range code in use.
    output logic            coreRun,         // Core clock released.
    output logic            coreTick         // Core clock enable.
);

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        ost_pkg::ost_state_t state;
        logic [15:0]         count;
        logic [15:0]         rtoCount;
        logic [15:0]         ckTarget;
        logic [7:0]          trim;
        logic [7:0]          rdData;
        logic                loaded;
        logic                fromReset;
        logic                rcSel;
        logic                xtalSel;
        logic [2:0]          range;
        logic                run;
        logic                tick;
        logic                badCode;
    } ost_ctl_t;

    ost_ctl_t cur;
    ost_ctl_t next_cur;
    logic     divTick;

    // -------------------------------------------------------------------
    // Delay decode
    // -------------------------------------------------------------------
    function automatic logic programmed(input logic fuse);
        return !fuse;
    endfunction : programmed

    // Wake-up cycle count for the fuse setting.
    function automatic logic [15:0] wakeCycles(input logic [3:0] src, input logic [1:0] sut);
        if (src == ost_pkg::SRC_RC) begin
            return ost_pkg::CK_6;
        end else if (!src[0]) begin
            return (sut == ost_pkg::SUT_00 || sut == ost_pkg::SUT_01) ?
                   ost_pkg::CK_258 : ost_pkg::CK_1K;
        end else begin
            return (sut == ost_pkg::SUT_00) ? ost_pkg::CK_1K : ost_pkg::CK_16K;
        end
    endfunction : wakeCycles

    // Watchdog cycles added after reset; zero for the plain 14-cycle case.
    function automatic logic [15:0] resetWdt(input logic [3:0] src, input logic [1:0] sut,
                                             input logic rstDis);
        logic [1:0] k;
        k = 2'h0;
        if (src == ost_pkg::SRC_RC) begin
            k = sut;
            if (rstDis && sut == ost_pkg::SUT_00) begin
                k = ost_pkg::SUT_01;
            end
            if (rstDis && sut == ost_pkg::SUT_10) begin
                k = ost_pkg::SUT_01;
            end
        end else if (!src[0]) begin
            k = (sut == ost_pkg::SUT_11) ? ost_pkg::SUT_01 : sut + 2'h1;
        end else begin
            k = (sut == ost_pkg::SUT_00) ? ost_pkg::SUT_10 : sut - 2'h1;
        end
        case (k)
            ost_pkg::SUT_01: return ost_pkg::WDT_4MS;
            ost_pkg::SUT_10: return ost_pkg::WDT_65MS;
            default:         return 16'h0000;
        endcase
    endfunction : resetWdt

    ost_divider u_div (
        .clk      (clk),
        .rst      (rst),
        .srcTick  (srcTick),
        .divEight (programmed(divideByEightFuse)),
        .coreTick (divTick)
    );

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.rdData = 8'h00;
        next_cur.tick = cur.run && divTick;
        next_cur.rcSel = (clockSourceFuses == ost_pkg::SRC_RC);
        next_cur.xtalSel = clockSourceFuses[3];
        next_cur.range = clockSourceFuses[3:1];
        next_cur.badCode = next_cur.rcSel && (startupTimeFuses == ost_pkg::SUT_11);
        if (!cur.loaded) begin
            next_cur.trim = factoryTrim;
            next_cur.loaded = 1'b1;
        end else if (wrEn && addr == ost_pkg::ADDR_RC_TRIM) begin
            next_cur.trim = wrData;
        end
        if (rdEn) begin
            case (addr)
                ost_pkg::ADDR_RC_TRIM: next_cur.rdData = cur.trim;
                ost_pkg::ADDR_STATUS:  next_cur.rdData = {4'h0, cur.badCode, cur.xtalSel,
                                                          cur.rcSel, cur.run};
                default:               next_cur.rdData = 8'h00;
            endcase
        end
        case (cur.state)
            ost_pkg::OST_ST_IDLE: begin
                next_cur.ckTarget = ost_pkg::CK_14;
                next_cur.rtoCount = resetWdt(clockSourceFuses, startupTimeFuses,
                                             programmed(resetPinDisableFuse));
                next_cur.count = 16'h0000;
                next_cur.state = ost_pkg::OST_ST_RTO;
            end
            ost_pkg::OST_ST_RTO: begin
                if (cur.rtoCount == 16'h0000) begin
                    next_cur.state = ost_pkg::OST_ST_CNT;
                end else if (wdtTick) begin
                    next_cur.rtoCount = cur.rtoCount - 16'h0001;
                end
            end
            ost_pkg::OST_ST_CNT: begin
                if (cur.count >= cur.ckTarget) begin
                    next_cur.run = 1'b1;
                    next_cur.state = ost_pkg::OST_ST_RUN;
                end else if (srcTick) begin
                    next_cur.count = cur.count + 16'h0001;
                end
            end
            ost_pkg::OST_ST_RUN: begin
                if (wakeReq) begin
                    next_cur.run = 1'b0;
                    next_cur.tick = 1'b0;
                    next_cur.count = 16'h0000;
                    next_cur.ckTarget = wakeCycles(clockSourceFuses, startupTimeFuses);
                    next_cur.state = ost_pkg::OST_ST_CNT;
                end
            end
            default: begin
                next_cur.state = ost_pkg::OST_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
            cur.trim <= ost_pkg::TRIM_FACTORY;
        end else begin
            cur <= next_cur;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign rdData        = cur.rdData;
    assign rcTrimValue   = cur.trim;
    assign rcSelect      = cur.rcSel;
    assign xtalSelect    = cur.xtalSel;
    assign oscRangeFuses = cur.range;
    assign coreRun       = cur.run;
    assign coreTick      = cur.tick;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    property p_gate;
        @(posedge clk) disable iff (rst) !cur.run |=> !cur.tick;
    endproperty
    a_gate: assert property (p_gate) else $error("core tick while gated");

    property p_trim_wr;
        @(posedge clk) disable iff (rst)
            (cur.loaded && wrEn && addr == ost_pkg::ADDR_RC_TRIM) |=> (rcTrimValue == $past(wrData));
    endproperty
    a_trim_wr: assert property (p_trim_wr) else $error("trim write lost");

    property p_rc_sel;
        @(posedge clk) disable iff (rst)
            (cur.loaded && clockSourceFuses == ost_pkg::SRC_RC) |=> rcSelect;
    endproperty
    a_rc_sel: assert property (p_rc_sel) else $error("rc not selected");

    property p_range;
        @(posedge clk) disable iff (rst)
            (cur.loaded && clockSourceFuses[3])
            |=> (oscRangeFuses == $past(clockSourceFuses[3:1]));
    endproperty
    a_range: assert property (p_range) else $error("range mismatch");

    sequence s_wake;
        cur.state == ost_pkg::OST_ST_RUN && wakeReq;
    endsequence

    property p_wake_gate;
        @(posedge clk) disable iff (rst) s_wake |=> !coreRun ##1 !coreRun;
    endproperty
    a_wake_gate: assert property (p_wake_gate) else $error("wake not gated");

    property p_rc_wake;
        @(posedge clk) disable iff (rst)
            (s_wake and (clockSourceFuses == ost_pkg::SRC_RC)) |=> (cur.ckTarget == ost_pkg::CK_6);
    endproperty
    a_rc_wake: assert property (p_rc_wake) else $error("rc wake count");

    property p_xtal_wake;
        @(posedge clk) disable iff (rst)
            (s_wake and clockSourceFuses[3] and !clockSourceFuses[0]
             and startupTimeFuses[1] == 1'b0) |=> (cur.ckTarget == ost_pkg::CK_258);
    endproperty
    a_xtal_wake: assert property (p_xtal_wake) else $error("short wake count");

    property p_rto_wdt;
        @(posedge clk) disable iff (rst)
            (cur.state == ost_pkg::OST_ST_RTO && cur.rtoCount != 16'h0000 && !wdtTick)
            |=> $stable(cur.rtoCount);
    endproperty
    a_rto_wdt: assert property (p_rto_wdt) else $error("timeout moved without wdt");

    property p_wdt_step;
        @(posedge clk) disable iff (rst)
            (cur.state == ost_pkg::OST_ST_RTO && cur.rtoCount != 16'h0000 && wdtTick)
            |=> (cur.rtoCount == $past(cur.rtoCount) - 16'h0001);
    endproperty
    a_wdt_step: assert property (p_wdt_step) else $error("timeout missed wdt tick");

    property p_xtal_rto;
        @(posedge clk) disable iff (rst)
            (!rst && cur.state == ost_pkg::OST_ST_IDLE && clockSourceFuses[3]
             && !clockSourceFuses[0] && startupTimeFuses == ost_pkg::SUT_11)
            |=> (cur.rtoCount == ost_pkg::WDT_4MS);
    endproperty
    a_xtal_rto: assert property (p_xtal_rto) else $error("short group reset delay");

    // -------------------------------------------------------------------
    // Start-up count checks
    // -------------------------------------------------------------------
    property p_cnt_step;
        @(posedge clk) disable iff (rst)
            (cur.state == ost_pkg::OST_ST_CNT && cur.count < cur.ckTarget && srcTick)
            |=> (cur.count == $past(cur.count) + 16'h0001);
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("start-up count missed tick");

    property p_release;
        @(posedge clk) disable iff (rst)
            (cur.state == ost_pkg::OST_ST_CNT && cur.count >= cur.ckTarget) |=> coreRun;
    endproperty
    a_release: assert property (p_release) else $error("core not released");

    property p_run_hold;
        @(posedge clk) disable iff (rst) (cur.run && !wakeReq) |=> coreRun;
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("core run dropped");

    property p_mid_wake;
        @(posedge clk) disable iff (rst)
            (s_wake and clockSourceFuses[3] and !clockSourceFuses[0] and startupTimeFuses[1])
            |=> (cur.ckTarget == ost_pkg::CK_1K);
    endproperty
    a_mid_wake: assert property (p_mid_wake) else $error("mid wake count");

    property p_long_wake;
        @(posedge clk) disable iff (rst)
            (s_wake and clockSourceFuses[3] and clockSourceFuses[0]
             and startupTimeFuses != ost_pkg::SUT_00) |=> (cur.ckTarget == ost_pkg::CK_16K);
    endproperty
    a_long_wake: assert property (p_long_wake) else $error("long wake count");

    // -------------------------------------------------------------------
    // Register port checks
    // -------------------------------------------------------------------
    // The design still sits in reset at the releasing edge, so the load shows two edges later.
    sequence s_unloaded;
        !cur.loaded ##1 !cur.loaded;
    endsequence

    property p_factory;
        @(posedge clk) disable iff (rst) s_unloaded |=> (rcTrimValue == $past(factoryTrim));
    endproperty
    a_factory: assert property (p_factory) else $error("factory trim not loaded");

    property p_rd_trim;
        @(posedge clk) disable iff (rst)
            (cur.loaded && rdEn && addr == ost_pkg::ADDR_RC_TRIM)
            |=> (rdData == $past(rcTrimValue));
    endproperty
    a_rd_trim: assert property (p_rd_trim) else $error("trim read wrong");

    property p_rd_idle;
        @(posedge clk) disable iff (rst) !rdEn |=> (rdData == 8'h00);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");

    property p_trim_hold;
        @(posedge clk) disable iff (rst)
            (cur.loaded && !(wrEn && addr == ost_pkg::ADDR_RC_TRIM)) |=> $stable(rcTrimValue);
    endproperty
    a_trim_hold: assert property (p_trim_hold) else $error("trim changed without write");

endmodule : ost_clock_ctrl

// ### logic/ost_pkg.sv
// Constants for the oscillator select, start-up delay and RC trim block.
// Assumes a single 50 MHz system clock and fuse levels that are static after reset.
package ost_pkg;

    // -------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------
    localparam logic [3:0] ADDR_RC_TRIM   = 4'h0;
    localparam logic [3:0] ADDR_STATUS    = 4'h1;
    localparam logic [7:0] TRIM_FACTORY   = 8'h80;
    localparam int         TRIM_RANGE_POS = 7;

    // -------------------------------------------------------------------
    // Fuse codes
    // -------------------------------------------------------------------
    localparam logic [3:0] SRC_RC         = 4'h2;
    localparam logic [2:0] RANGE_0P4_0P9  = 3'h4;
    localparam logic [2:0] RANGE_0P9_3P0  = 3'h5;
    localparam logic [2:0] RANGE_3P0_8P0  = 3'h6;
    localparam logic [2:0] RANGE_8P0_16P0 = 3'h7;
    localparam logic [1:0] SUT_00         = 2'h0;
    localparam logic [1:0] SUT_01         = 2'h1;
    localparam logic [1:0] SUT_10         = 2'h2;
    localparam logic [1:0] SUT_11         = 2'h3;

    // -------------------------------------------------------------------
    // Start-up counts
    // -------------------------------------------------------------------
    localparam logic [15:0] CK_6      = 16'h0006;
    localparam logic [15:0] CK_258    = 16'h0102;
    localparam logic [15:0] CK_1K     = 16'h0400;
    localparam logic [15:0] CK_16K    = 16'h4000;
    localparam logic [15:0] CK_14     = 16'h000E;
    localparam logic [15:0] WDT_4MS   = 16'h0200;
    localparam logic [15:0] WDT_65MS  = 16'h2000;
    localparam logic [2:0]  DIV8_LAST = 3'h7;

    typedef enum logic [1:0] {
        OST_ST_IDLE = 2'b00,
        OST_ST_RTO  = 2'b01,
        OST_ST_CNT  = 2'b11,
        OST_ST_RUN  = 2'b10
    } ost_state_t;

endpackage : ost_pkg

// ### logic/ost_divider.sv
// Programmable clock enable divider: passes every cycle or one cycle in eight.
// Assumes the enable input marks cycles of the selected source clock.
module ost_divider (
    input  wire logic clk,      // System clock.
    input  wire logic rst,      // Asynchronous reset, active high.
    input  wire logic srcTick,  // Selected source cycle enable.
    input  wire logic divEight, // High to divide by eight.
    output logic      coreTick  // Resulting core clock enable.
);

    typedef struct packed {
        logic [2:0] count;
        logic       tick;
    } ost_div_t;

    ost_div_t cur;
    ost_div_t next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        if (srcTick) begin
            next_cur.count = cur.count + 3'h1;
            next_cur.tick = !divEight || (cur.count == ost_pkg::DIV8_LAST);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign coreTick = cur.tick;

endmodule : ost_divider

// ### dv/ost_xtal_model.sv
// External resonator model: emits one source tick per oscillator cycle.
// Assumes run follows the crystal select output of the block.
module ost_xtal_model (
    input  wire logic clk,  // System clock.
    input  wire logic rst,  // Asynchronous reset, active high.
    input  wire logic run,  // Oscillator powered.
    input  wire logic slow, // High for one tick every two cycles.
    output logic      tick  // Source cycle enable.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic phase;
    // A ceramic part, so the lowest range and the short start-up codes are legal.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase <= 1'b0;
            tick  <= 1'b0;
        end else begin
            phase <= slow ? ~phase : 1'b1;
            tick  <= run & (~slow | phase);
        end
    end
endmodule : ost_xtal_model

// ### dv/tb_top.sv
// Self-checking bench for the oscillator select and start-up block.
// Assumes one 50 MHz clock; the watchdog ticks every cycle, every other one in slow tests.
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [3:0] s; logic [1:0] t; logic rpd; logic dv; int wdt; int wk;
                    logic slow;} ost_cfg_t;
    logic clk = 0, rst, rpd, dv, wakeReq, wdtTick, wrEn, rdEn, slow, xTick, rdPend = 0;
    logic [3:0] src, addr;
    logic [1:0] sut;
    logic [7:0] factoryTrim, wrData, rdData, rcTrimValue, expRd;
    logic [2:0] oscRangeFuses;
    logic       rcSelect, xtalSelect, coreRun, coreTick, srcTick;
    logic [7:0] expQ[$];
    int         miscompares = 0, total_checks = 0;
    ost_cfg_t   cfg[10] = '{
        '{4'h2, 2'h0, 1, 0, 0, 6, 0},
        '{4'h2, 2'h1, 1, 1, 512, 6, 0},
        '{4'h2, 2'h2, 0, 1, 512, 6, 0},
        '{4'h8, 2'h0, 1, 1, 512, 258, 0},
        '{4'hA, 2'h1, 1, 1, 8192, 258, 1},
        '{4'hC, 2'h2, 1, 1, 0, 1024, 0},
        '{4'hD, 2'h0, 1, 1, 8192, 1024, 1},
        '{4'hF, 2'h1, 1, 1, 0, 16384, 0},
        '{4'h2, 2'h3, 1, 1, 0, 6, 0},
        '{4'hE, 2'h3, 1, 1, 512, 1024, 0}};
    always #10 clk = ~clk;
    // The watchdog oscillator runs at half rate in the slow-source tests.
    always @(posedge clk) wdtTick <= slow ? ~wdtTick : 1'b1;
    assign srcTick = xtalSelect ? xTick : rcSelect;
    ost_xtal_model ost_xtal_model_i (.clk(clk), .rst(rst), .run(xtalSelect), .slow(slow),
                                     .tick(xTick));
    ost_clock_ctrl ost_clock_ctrl_i (.clk(clk), .rst(rst), .clockSourceFuses(src),
        .startupTimeFuses(sut), .resetPinDisableFuse(rpd), .divideByEightFuse(dv),
        .factoryTrim(factoryTrim), .wakeReq(wakeReq), .srcTick(srcTick),
        .wdtTick(wdtTick), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
        .rdData(rdData), .rcTrimValue(rcTrimValue), .rcSelect(rcSelect),
        .xtalSelect(xtalSelect), .oscRangeFuses(oscRangeFuses), .coreRun(coreRun),
        .coreTick(coreTick));
    // Read monitor: every answered read is matched with the oldest expected note.
    always @(posedge clk) begin
        if (rdPend === 1'b1 && expQ.size() > 0) begin
            expRd = expQ.pop_front();
            `CHK("read data", expRd, rdData)
        end
        rdPend <= rdEn;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wrData <= d; wrEn <= 1'b1;
        @(posedge clk);
        wrEn <= 1'b0;
        @(posedge clk);
        if (a == 4'h0) `CHK("trim out", d, rcTrimValue)
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        expQ.push_back(e);
        @(posedge clk);
        addr <= a; rdEn <= 1'b1;
        @(posedge clk);
        rdEn <= 1'b0;
    endtask : rd
    task automatic reg_test();
        logic [7:0] v[4];
        v = '{8'h7F, 8'h80, 8'h00, 8'($urandom)};
        // No nonvolatile write happens in this bench, so any trim value may be tried.
        foreach (v[k]) begin
            wr(4'h0, v[k]);
            rd(4'h0, v[k]);
        end
        rd(4'h1, 8'h03);
        wr(4'h1, 8'hFF);
        rd(4'h0, v[3]);
        rd(4'h5, 8'h00);
        repeat (3) @(posedge clk);
    endtask : reg_test
    task automatic run_cfg(input int i);
        int n, lo, per, k;
        logic [7:0] ft;
        logic rc;
        per = cfg[i].slow ? 2 : 1;
        rc = (cfg[i].s == 4'h2);
        ft = 8'($urandom);
        @(posedge clk);
        rst <= 1'b1; src <= cfg[i].s; sut <= cfg[i].t; rpd <= cfg[i].rpd;
        dv <= cfg[i].dv; slow <= cfg[i].slow; factoryTrim <= ft;
        repeat (3) @(posedge clk);
        `CHK("trim in reset", 8'h80, rcTrimValue)
        rst <= 1'b0;
        n = 0;
        while (coreRun !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        lo = (cfg[i].wdt + 14) * per;
        `CHK("reset delay", 1'b1, n >= lo - 2 && n <= lo + per + 4)
        `CHK("trim load", ft, rcTrimValue)
        `CHK("rc select", cfg[i].s == 4'h2, rcSelect)
        `CHK("xtal select", cfg[i].s[3], xtalSelect)
        if (cfg[i].s[3]) `CHK("range", cfg[i].s[3:1], oscRangeFuses)
        rd(ost_pkg::ADDR_STATUS, {4'h0, rc && cfg[i].t == 2'h3, cfg[i].s[3], rc, 1'b1});
        if (i == 0) reg_test();
        @(posedge clk);
        wakeReq <= 1'b1;
        @(posedge clk);
        wakeReq <= 1'b0;
        @(posedge clk);
        `CHK("gated on wake", 1'b0, coreRun)
        n = 1;
        while (coreRun !== 1'b1 && n < 40000) begin
            @(posedge clk);
            n++;
        end
        lo = cfg[i].wk * per;
        `CHK("wake delay", 1'b1, n >= lo - 2 && n <= lo + per + 6)
        k = 0;
        repeat (64 * per) begin
            @(posedge clk);
            if (coreTick === 1'b1) k++;
        end
        lo = cfg[i].dv ? 64 : 8;
        `CHK("core ticks", 1'b1, k >= lo - 1 && k <= lo + 1)
        $display("test %0d done", i);
    endtask : run_cfg
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        rst <= 1'b1; src <= 4'h2; sut <= 2'h0; rpd <= 1'b1; dv <= 1'b1; slow <= 1'b0;
        factoryTrim <= 8'h00; wakeReq <= 1'b0; addr <= 4'h0;
        wrData <= 8'h00; wrEn <= 1'b0; rdEn <= 1'b0;
        void'($urandom(32'h1a5b));
        for (int i = 0; i < 10; i++) run_cfg(i);
        tally_and_finish();
    end
    // Hang guard, well beyond the longest expected run.
    initial begin
        #(20 * 95000);
        miscompares++;
        tally_and_finish();
    end
endmodule : tb_top
